/* design/gauge_cfg_mem.sv */
module gauge_cfg_mem (
  // Clock
  input  wire logic                          i_clk,
  // Write port
  input  wire logic                          i_we,
  input  wire logic [gauge_pkg::MEM_AW-1:0]  i_waddr,
  input  wire logic [7:0]                    i_wdata,
  // Read port, one cycle latency
  input  wire logic [gauge_pkg::MEM_AW-1:0]  i_raddr,
  output logic      [7:0]                    o_rdata
);

  logic [7:0] mem_q [0:(1<<gauge_pkg::MEM_AW)-1];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end

endmodule : gauge_cfg_mem

/* design/gauge_power_mode_sequencer.sv */
// Contract
// RQ1: A reset command write resets the device and restores every register default.
// RQ2: Ready-for-setup flag is set once the reset sequence finishes.
// RQ3: Entering shutdown acts as a full reset.
// RQ4: After power-up or any reset, sit in shutdown with only bus monitoring.
// RQ5: Host wakes the device by addressing it before configuring.
// RQ6: A read addressed in shutdown is not acknowledged; wakes to active if battery present.
// RQ7: On wake, set the ready-for-setup flag and assert the interrupt.
// RQ8: Host writes the gauging-start bit after configuration.
// RQ9: Status register shows gauging in progress once started.
// RQ10: While gauging, writes to 0x20 through 0x3F are discarded.
// RQ11: While gauging, writes to reserved gauge registers are ignored.
// RQ12: Once gauging, host should only write runtime, mask, clear and mode registers.
// RQ13: Mode bits select active, hibernate or shutdown; device enters it.
// RQ14: Active mode runs measurement and gauging, results readable.
// RQ15: Hibernate keeps register access while front end and processor are off.
// RQ16: Hibernate retains memory and register contents.
// RQ17: Shutdown does no gauging and refuses all register access.
// RQ18: Bus slave works in Standard and Fast modes up to 400 kHz.
// RQ19: Voltage and temperature threshold events reach the interrupt output.
// RQ20: Low and zero charge-level events reach the interrupt output.
// RQ21: Flags stay set until host writes one to the clear bit.
// RQ22: Interrupt pin stays low until all unmasked pending flags are cleared.
// RQ23: Write lock applies exactly while gauging-start bit is set.
// RQ24: Ready flag interrupts only when unmasked; masks default to enabled.

module gauge_link (
  // Link clock and system reset
  input  wire logic                  i_link_clk,
  input  wire logic                  i_resetn,
  // Bus pins
  input  wire logic                  i_scl,
  input  wire logic                  i_sda,
  output logic                       o_sda_oe,
  // Core side
  input  wire logic                  i_down,
  input  wire logic                  i_ack_tgl,
  input  wire logic [7:0]            i_rdata,
  output gauge_pkg::bus_req_t        o_req,
  output logic                       o_req_tgl,
  output logic                       o_wake_tgl
);

  typedef struct packed {
    logic                scl_s1, scl_s2, scl_p;
    logic                sda_s1, sda_s2, sda_p;
    logic                down_s1, down_s2;
    logic                ack_s1, ack_s2;
    gauge_pkg::link_st_t st;
    gauge_pkg::link_st_t after;
    logic [3:0]          cnt;
    logic [7:0]          sh;
    logic [7:0]          ptr;
    logic                mnack;
    gauge_pkg::bus_req_t req;
    logic                req_tgl;
    logic                wake_tgl;
    logic                sda_oe;
  } link_t;

  link_t      q, d;
  logic [1:0] rst_q;
  logic       rise, fall, start, stop;
  logic [7:0] tx;

  // Reset brought into the link domain
  always_ff @(posedge i_link_clk) begin
    rst_q <= {rst_q[0], i_resetn};
  end

  // Pins pass two flops before use; edges on oversampled levels
  assign rise  = q.scl_s2 & ~q.scl_p;
  assign fall  = ~q.scl_s2 & q.scl_p;
  assign start = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
  assign stop  = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
  // Data not yet answered by the core goes out as idle ones
  assign tx = (q.ack_s2 == q.req_tgl) ? i_rdata : gauge_pkg::IDLE_BYTE;

  always_comb begin
    d = q;
    d.scl_s1  = i_scl;
    d.scl_s2  = q.scl_s1;
    d.scl_p   = q.scl_s2;
    d.sda_s1  = i_sda;
    d.sda_s2  = q.sda_s1;
    d.sda_p   = q.sda_s2;
    d.down_s1 = i_down;
    d.down_s2 = q.down_s1;
    d.ack_s1  = i_ack_tgl;
    d.ack_s2  = q.ack_s1;
    if (start) begin
      d.st     = gauge_pkg::LK_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.st     = gauge_pkg::LK_IDLE;
      d.sda_oe = 1'b0;
    end else if (rise) begin
      if ((q.st == gauge_pkg::LK_ADDR || q.st == gauge_pkg::LK_REG ||
           q.st == gauge_pkg::LK_WDATA) && q.cnt != gauge_pkg::BITS_BYTE) begin
        d.sh  = {q.sh[6:0], q.sda_s2};
        d.cnt = q.cnt + 4'h1;
      end
      if (q.st == gauge_pkg::LK_RACK) begin
        d.mnack = q.sda_s2;
      end
    end else if (fall) begin
      unique case (q.st)
        gauge_pkg::LK_IDLE: begin
        end
        gauge_pkg::LK_ADDR: begin
          if (q.cnt == gauge_pkg::BITS_BYTE) begin
            d.st = gauge_pkg::LK_IDLE;
            if (q.sh[7:1] == gauge_pkg::DEV_ADDR) begin
              if (q.down_s2) begin
                // No acknowledge while down; a read wakes  [RQ6] [RQ17]
                d.wake_tgl = q.wake_tgl ^ q.sh[0];
              end else begin
                d.sda_oe = 1'b1;
                d.st     = gauge_pkg::LK_ACK;
                d.after  = q.sh[0] ? gauge_pkg::LK_RDATA : gauge_pkg::LK_REG;
                if (q.sh[0]) begin
                  d.req     = '{write: 1'b0, addr: q.ptr, data: 8'h00};
                  d.req_tgl = ~q.req_tgl;
                end
              end
            end
          end
        end
        gauge_pkg::LK_REG: begin
          if (q.cnt == gauge_pkg::BITS_BYTE) begin
            d.ptr    = q.sh;
            d.sda_oe = 1'b1;
            d.st     = gauge_pkg::LK_ACK;
            d.after  = gauge_pkg::LK_WDATA;
          end
        end
        gauge_pkg::LK_WDATA: begin
          if (q.cnt == gauge_pkg::BITS_BYTE) begin
            d.req     = '{write: 1'b1, addr: q.ptr, data: q.sh};
            d.req_tgl = ~q.req_tgl;
            d.ptr     = q.ptr + 8'h01;
            d.sda_oe  = 1'b1;
            d.st      = gauge_pkg::LK_ACK;
            d.after   = gauge_pkg::LK_WDATA;
          end
        end
        gauge_pkg::LK_ACK, gauge_pkg::LK_RACK: begin
          d.sda_oe = 1'b0;
          d.cnt    = 4'h0;
          d.st     = q.after;
          if (q.st == gauge_pkg::LK_RACK && q.mnack) begin
            d.st = gauge_pkg::LK_IDLE;
          end else if (q.after == gauge_pkg::LK_RDATA) begin
            // Prefetch the next byte while this one shifts out
            d.sh      = tx;
            d.sda_oe  = ~tx[7];
            d.cnt     = 4'h1;
            d.ptr     = q.ptr + 8'h01;
            d.req     = '{write: 1'b0, addr: q.ptr + 8'h01, data: 8'h00};
            d.req_tgl = ~q.req_tgl;
          end
        end
        gauge_pkg::LK_RDATA: begin
          if (q.cnt == gauge_pkg::BITS_BYTE) begin
            d.sda_oe = 1'b0;
            d.st     = gauge_pkg::LK_RACK;
            d.after  = gauge_pkg::LK_RDATA;
          end else begin
            d.sda_oe = ~q.sh[6];
            d.sh     = {q.sh[6:0], 1'b0};
            d.cnt    = q.cnt + 4'h1;
          end
        end
        default: begin
          d.st = gauge_pkg::LK_IDLE;
        end
      endcase
    end
    if (!rst_q[1]) begin
      d.st       = gauge_pkg::LK_IDLE;
      d.after    = gauge_pkg::LK_IDLE;
      d.cnt      = 4'h0;
      d.sda_oe   = 1'b0;
      d.ptr      = 8'h00;
      d.mnack    = 1'b0;
      d.req_tgl  = 1'b0;
      d.wake_tgl = 1'b0;
    end
  end

  always_ff @(posedge i_link_clk) begin
    q <= d;
  end

  assign o_sda_oe   = q.sda_oe;
  assign o_req      = q.req;
  assign o_req_tgl  = q.req_tgl;
  assign o_wake_tgl = q.wake_tgl;

endmodule : gauge_link

module gauge_power_mode_sequencer (
  // System clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Link clock and bus pins
  input  wire logic         i_link_clk,
  input  wire logic         i_scl,
  input  wire logic         i_sda,
  output logic              o_sda_o,
  output logic              o_sda_oe,
  // Interrupt pin, open drain
  output logic              o_int_n_o,
  output logic              o_int_n_oe,
  // Battery and gauge engine
  input  wire logic         i_vbat_ok,
  input  wire logic [15:0]  i_alarm_evt,
  output logic              o_gauge_run,
  output logic              o_afe_power,
  output logic              o_cpu_clk_en,
  output logic [1:0]        o_power_state
);

  typedef struct packed {
    gauge_pkg::pstate_t    ps;
    logic [2:0]            mode;
    logic [15:0]           flags;
    logic [15:0]           mask;
    logic [5:0]            idx;
    logic                  req_s1, req_s2, req_p;
    logic                  wake_s1, wake_s2, wake_p;
    logic                  vbat_s1, vbat_s2;
    logic                  rd_pend;
    logic [7:0]            rd_addr;
    logic [7:0]            rdata;
    logic                  ack_tgl;
    logic                  down;
    logic                  int_oe;
    gauge_pkg::power_ctl_t pctl;
  } core_t;

  core_t               q, d;
  gauge_pkg::bus_req_t lreq;
  logic                lreq_tgl, lwake_tgl, lsda_oe;
  logic                mem_we;
  logic [5:0]          mem_waddr, mem_raddr;
  logic [7:0]          mem_wdata, mem_rdata;
  logic                req_edge, wake_edge, lock, in_mem;
  logic [15:0]         clr, set;
  logic [1:0]          pm;

  gauge_link u_link (
    .i_link_clk (i_link_clk),
    .i_resetn   (i_resetn),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_sda_oe   (lsda_oe),
    .i_down     (q.down),
    .i_ack_tgl  (q.ack_tgl),
    .i_rdata    (q.rdata),
    .o_req      (lreq),
    .o_req_tgl  (lreq_tgl),
    .o_wake_tgl (lwake_tgl)
  );

  gauge_cfg_mem u_mem (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata)
  );

  // Request word is held steady by the link until the next toggle
  assign req_edge  = q.req_s2 ^ q.req_p;
  assign wake_edge = q.wake_s2 ^ q.wake_p;
  assign lock      = q.mode[gauge_pkg::MODE_START_BIT];  // [RQ23]
  assign in_mem    = lreq.addr >= gauge_pkg::CFG_FIRST && lreq.addr <= gauge_pkg::RSV_LAST;
  assign mem_raddr = 6'(lreq.addr - gauge_pkg::CFG_FIRST);
  assign pm        = q.mode[gauge_pkg::MODE_PM_LSB +: 2];

  always_comb begin
    d         = q;
    clr       = 16'h0000;
    set       = 16'h0000;
    mem_we    = 1'b0;
    mem_waddr = mem_raddr;
    mem_wdata = lreq.data;
    d.req_s1  = lreq_tgl;
    d.req_s2  = q.req_s1;
    d.req_p   = q.req_s2;
    d.wake_s1 = lwake_tgl;
    d.wake_s2 = q.wake_s1;
    d.wake_p  = q.wake_s2;
    d.vbat_s1 = i_vbat_ok;
    d.vbat_s2 = q.vbat_s1;
    d.rd_pend = 1'b0;
    unique case (q.ps)
      gauge_pkg::PS_INIT: begin
        // Wipe configuration memory, then rest in shutdown  [RQ4]
        mem_we    = 1'b1;
        mem_waddr = q.idx;
        mem_wdata = 8'h00;
        d.idx     = q.idx + 6'h01;
        if (q.idx == gauge_pkg::MEM_LAST) begin
          d.ps = gauge_pkg::PS_SHUTDOWN;
          set[gauge_pkg::READY_BIT] = 1'b1;  // [RQ2]
        end
      end
      gauge_pkg::PS_SHUTDOWN: begin
        if (wake_edge && q.vbat_s2) begin
          d.ps = gauge_pkg::PS_ACTIVE;  // [RQ6]
          set[gauge_pkg::READY_BIT] = 1'b1;  // [RQ7]
        end
      end
      gauge_pkg::PS_ACTIVE, gauge_pkg::PS_HIBERNATE: begin
        // Hibernate keeps all state and register access  [RQ15] [RQ16]
        set = i_alarm_evt;  // [RQ19] [RQ20]
        set[gauge_pkg::READY_BIT] = 1'b0;
        unique case (pm)
          gauge_pkg::PM_HIBERNATE: d.ps = gauge_pkg::PS_HIBERNATE;  // [RQ13]
          gauge_pkg::PM_SHUTDOWN:  d.ps = gauge_pkg::PS_INIT;  // [RQ3]
          default:                 d.ps = gauge_pkg::PS_ACTIVE;
        endcase
        if (q.rd_pend) begin
          unique case (q.rd_addr)
            gauge_pkg::REG_MODE:    d.rdata = {5'h00, q.mode};
            gauge_pkg::REG_STATUS:  d.rdata = {5'h00, q.ps, q.pctl.gauge_run};  // [RQ9]
            gauge_pkg::REG_INT_LO:  d.rdata = q.flags[7:0];
            gauge_pkg::REG_INT_HI:  d.rdata = q.flags[15:8];
            gauge_pkg::REG_MASK_LO: d.rdata = q.mask[7:0];
            gauge_pkg::REG_MASK_HI: d.rdata = q.mask[15:8];
            default: begin
              d.rdata = (q.rd_addr >= gauge_pkg::CFG_FIRST &&
                         q.rd_addr <= gauge_pkg::RSV_LAST) ? mem_rdata : 8'h00;
            end
          endcase
          d.ack_tgl = q.req_s2;
        end
        if (req_edge && !lreq.write) begin
          d.rd_pend = 1'b1;
          d.rd_addr = lreq.addr;
        end else if (req_edge) begin
          d.ack_tgl = q.req_s2;
          // Locked window covers config and reserved gauge registers  [RQ10] [RQ11]
          mem_we = in_mem && !lock;
          unique case (lreq.addr)
            gauge_pkg::REG_MODE:    d.mode = lreq.data[2:0];
            gauge_pkg::REG_MASK_LO: d.mask[7:0] = lreq.data;
            gauge_pkg::REG_MASK_HI: d.mask[15:8] = lreq.data;
            gauge_pkg::REG_CLR_LO:  clr[7:0] = lreq.data;  // [RQ21]
            gauge_pkg::REG_CLR_HI:  clr[15:8] = lreq.data;  // [RQ21]
            gauge_pkg::REG_RESET: begin
              if (lreq.data == gauge_pkg::RESET_KEY) begin
                d.ps = gauge_pkg::PS_INIT;  // [RQ1]
              end
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        d.ps = gauge_pkg::PS_INIT;
      end
    endcase
    // Set wins over a clear in the same cycle
    d.flags = (q.flags & ~clr) | set;  // [RQ21]
    if (d.ps == gauge_pkg::PS_INIT && q.ps != gauge_pkg::PS_INIT) begin
      d.mode  = gauge_pkg::MODE_RESET;  // [RQ1] [RQ3]
      d.flags = gauge_pkg::FLAGS_RESET;
      d.mask  = gauge_pkg::MASK_RESET;  // [RQ24]
      d.idx   = gauge_pkg::IDX_RESET;
    end
    if (!i_resetn) begin
      d.ps      = gauge_pkg::PS_INIT;
      d.mode    = gauge_pkg::MODE_RESET;
      d.flags   = gauge_pkg::FLAGS_RESET;
      d.mask    = gauge_pkg::MASK_RESET;
      d.idx     = gauge_pkg::IDX_RESET;
      d.rd_pend = 1'b0;
      d.rd_addr = 8'h00;
      d.rdata   = 8'h00;
      d.ack_tgl = 1'b0;
      d.req_p   = 1'b0;
      d.wake_p  = 1'b0;
    end
    // Pin low until every unmasked pending flag is cleared  [RQ22] [RQ24]
    d.int_oe = (d.ps == gauge_pkg::PS_ACTIVE || d.ps == gauge_pkg::PS_HIBERNATE) &&
               |(d.flags & ~d.mask);
    d.down   = !(d.ps == gauge_pkg::PS_ACTIVE || d.ps == gauge_pkg::PS_HIBERNATE);  // [RQ17]
    d.pctl.afe_power  = d.ps == gauge_pkg::PS_ACTIVE;  // [RQ14] [RQ15]
    d.pctl.cpu_clk_en = d.ps == gauge_pkg::PS_ACTIVE;
    d.pctl.gauge_run  = d.ps == gauge_pkg::PS_ACTIVE &&
                        d.mode[gauge_pkg::MODE_START_BIT];  // [RQ14]
  end

  always_ff @(posedge i_clk) begin
    q <= d;
  end

  // Bus slave oversamples the bus pins on the link clock; no stretching needed at 400 kHz  [RQ18]
  assign o_sda_o       = 1'b0;
  assign o_sda_oe      = lsda_oe;
  assign o_int_n_o     = 1'b0;
  assign o_int_n_oe    = q.int_oe;
  assign o_gauge_run   = q.pctl.gauge_run;
  assign o_afe_power   = q.pctl.afe_power;
  assign o_cpu_clk_en  = q.pctl.cpu_clk_en;
  assign o_power_state = q.ps;

endmodule : gauge_power_mode_sequencer

/* pkg/gauge_pkg.sv */
package gauge_pkg;

  // Power states of the sequencer
  typedef enum logic [1:0] {
    PS_INIT      = 2'b00,
    PS_SHUTDOWN  = 2'b01,
    PS_ACTIVE    = 2'b10,
    PS_HIBERNATE = 2'b11
  } pstate_t;

  // Link-side receiver states; 3'b111 is unused
  typedef enum logic [2:0] {
    LK_IDLE  = 3'b000,
    LK_ADDR  = 3'b001,
    LK_REG   = 3'b010,
    LK_WDATA = 3'b011,
    LK_RDATA = 3'b100,
    LK_ACK   = 3'b101,
    LK_RACK  = 3'b110
  } link_st_t;

  // Power mode request codes in the mode register
  localparam logic [1:0] PM_ACTIVE    = 2'b00;
  localparam logic [1:0] PM_HIBERNATE = 2'b01;
  localparam logic [1:0] PM_SHUTDOWN  = 2'b10;

  // Slave address (arbitrary value)
  localparam logic [6:0] DEV_ADDR = 7'h36;

  // Register map
  localparam logic [7:0] REG_MODE    = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h11;
  localparam logic [7:0] REG_INT_LO  = 8'h12;
  localparam logic [7:0] REG_INT_HI  = 8'h13;
  localparam logic [7:0] REG_MASK_LO = 8'h14;
  localparam logic [7:0] REG_MASK_HI = 8'h15;
  localparam logic [7:0] REG_CLR_LO  = 8'h16;
  localparam logic [7:0] REG_CLR_HI  = 8'h17;
  localparam logic [7:0] REG_RESET   = 8'h18;
  localparam logic [7:0] RESET_KEY   = 8'hA5;
  localparam logic [7:0] CFG_FIRST   = 8'h20;
  localparam logic [7:0] CFG_LAST    = 8'h3F;
  localparam logic [7:0] RSV_FIRST   = 8'h40;
  localparam logic [7:0] RSV_LAST    = 8'h5F;

  // Mode register fields
  localparam int MODE_START_BIT = 0;
  localparam int MODE_PM_LSB    = 1;

  // Configuration memory
  localparam int         MEM_AW   = 6;
  localparam logic [5:0] MEM_LAST = 6'h3F;

  // Interrupt flags
  localparam int          READY_BIT   = 11;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET  = 16'h0000;
  localparam logic [2:0]  MODE_RESET  = 3'h0;
  localparam logic [5:0]  IDX_RESET   = 6'h00;
  localparam logic [7:0]  IDLE_BYTE   = 8'hFF;
  localparam logic [3:0]  BITS_BYTE   = 4'h8;

  // Register access passed from the link domain
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } bus_req_t;

  // Power controls toward the gauge core and analog front end
  typedef struct packed {
    logic gauge_run;
    logic afe_power;
    logic cpu_clk_en;
  } power_ctl_t;

endpackage : gauge_pkg

/* verification/gauge_host_model.sv */
module gauge_host_model (
  // Bus pins, open drain
  input  wire logic i_sda,
  output logic      o_scl_low,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quarter bit; a whole bit is 2.5 us, so 400 kHz at most
  localparam int QTR = 625;

  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end

  task automatic bus_step(input logic scl_low, input logic sda_low);
    o_scl_low = scl_low;
    o_sda_low = sda_low;
    #QTR;
  endtask : bus_step

  task automatic bus_start();
    bus_step(o_scl_low, 1'b0);
    bus_step(1'b0, 1'b0);
    bus_step(1'b0, 1'b1);
    bus_step(1'b1, 1'b1);
  endtask : bus_start

  task automatic bus_stop();
    bus_step(1'b1, 1'b1);
    bus_step(1'b0, 1'b1);
    bus_step(1'b0, 1'b0);
    bus_step(1'b0, 1'b0);
  endtask : bus_stop

  task automatic bus_bit(input logic b, output logic s);
    bus_step(1'b1, !b);
    bus_step(1'b0, !b);
    s = i_sda;
    bus_step(1'b0, !b);
    bus_step(1'b1, !b);
  endtask : bus_bit

  // Ninth bit always released: reads end with a nack
  task automatic bus_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(tx[i], s);
      rx[i] = s;
    end
    bus_bit(1'b1, s);
    ack = !s;
  endtask : bus_byte

  task automatic wr(input logic [7:0] ra, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    a1 = 1'b0;
    a2 = 1'b0;
    bus_start();
    bus_byte({gauge_pkg::DEV_ADDR, 1'b0}, rx, a0);
    if (a0) begin
      bus_byte(ra, rx, a1);
      bus_byte(d, rx, a2);
    end
    bus_stop();
    ok = a0 && a1 && a2;
  endtask : wr

  task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    bus_start();
    bus_byte({gauge_pkg::DEV_ADDR, 1'b0}, d, a0);
    bus_byte(ra, d, a1);
    bus_start();
    bus_byte({gauge_pkg::DEV_ADDR, 1'b1}, d, a2);
    bus_byte(8'hFF, d, a3);
    bus_stop();
    ok = a0 && a1 && a2;
  endtask : rd

  task automatic wake(output logic ok);
    logic [7:0] rx;
    bus_start();
    bus_byte({gauge_pkg::DEV_ADDR, 1'b1}, rx, ok);
    bus_stop();
  endtask : wake
endmodule : gauge_host_model

/* verification/gauge_seq_props.sv */
module gauge_seq_props (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_resetn,
  // Watched outputs
  input wire logic       o_sda_oe,
  input wire logic       o_int_n_oe,
  input wire logic       o_gauge_run,
  input wire logic       o_afe_power,
  input wire logic       o_cpu_clk_en,
  input wire logic [1:0] o_power_state
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // An ack may outlast a shutdown write by one bit time, hence the long count
  logic [7:0]  asleep_q;
  logic [10:0] since_ack_q;

  always_ff @(posedge i_clk) begin
    if (!i_resetn || o_power_state[1]) begin
      asleep_q <= 8'h00;
    end else if (asleep_q != 8'hFF) begin
      asleep_q <= asleep_q + 8'h01;
    end
    if (!i_resetn) begin
      since_ack_q <= 11'h7FF;
    end else if (o_sda_oe) begin
      since_ack_q <= 11'h000;
    end else if (since_ack_q != 11'h7FF) begin
      since_ack_q <= since_ack_q + 11'h001;
    end
  end

  reset_to_shut_a: assert property ($rose(i_resetn) |-> ##[60:72] o_power_state == 2'b01)
    else $error("no shutdown after reset wipe");
  wipe_to_shut_a: assert property (o_power_state == 2'b00 && $past(o_power_state) != 2'b00
    |-> ##[60:72] o_power_state == 2'b01) else $error("wipe did not end in shutdown");
  wake_source_a: assert property ($rose(o_power_state == 2'b10) |->
    $past(o_power_state) != 2'b00) else $error("active entered from wipe");
  wake_int_a: assert property ($past(o_power_state) == 2'b01 && o_power_state == 2'b10
    |-> ##[0:2] o_int_n_oe) else $error("no interrupt after wake");
  int_gated_a: assert property (!o_power_state[1] && !$past(o_power_state[1])
    |-> !o_int_n_oe) else $error("interrupt while asleep");
  power_gated_a: assert property (o_afe_power || o_cpu_clk_en || o_gauge_run |->
    o_power_state == 2'b10 || $past(o_power_state) == 2'b10) else $error("power outside active");
  active_power_a: assert property (o_power_state == 2'b10 && $past(o_power_state) == 2'b10
    |-> o_afe_power && o_cpu_clk_en) else $error("front end off in active");
  no_ack_asleep_a: assert property (asleep_q == 8'hFF |-> !o_sda_oe)
    else $error("ack while asleep");
  int_clear_a: assert property ($fell(o_int_n_oe) && o_power_state[1] &&
    $past(o_power_state[1]) |-> since_ack_q < 11'h4B0) else $error("interrupt fell unasked");

  cover property ($rose(o_gauge_run));
  cover property (o_power_state == 2'b11);
  cover property ($fell(o_int_n_oe) && o_power_state[1]);
endmodule : gauge_seq_props

bind gauge_power_mode_sequencer gauge_seq_props u_gauge_seq_props (
  .i_clk(i_clk), .i_resetn(i_resetn), .o_sda_oe(o_sda_oe), .o_int_n_oe(o_int_n_oe),
  .o_gauge_run(o_gauge_run), .o_afe_power(o_afe_power), .o_cpu_clk_en(o_cpu_clk_en),
  .o_power_state(o_power_state)
);

/* verification/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk;
  logic        i_resetn;
  logic        link_clk;
  logic        vbat_ok;
  logic [15:0] evt;
  logic [15:0] ev;
  logic        scl_low;
  logic        sda_low;
  logic        sda_oe;
  logic        int_oe;
  logic        sda_o, int_o;
  logic        run;
  logic        afe;
  logic        cpu;
  logic [1:0]  pst;
  logic        ok;
  logic [7:0]  cfg_d [2];
  int          miscompares;
  int          checks_done;
  int          seed;
  int          off;
  localparam logic [15:0] RDY = 16'h0001 << gauge_pkg::READY_BIT;
  localparam logic [7:0]  LOCKED [2] = '{gauge_pkg::CFG_LAST, gauge_pkg::RSV_FIRST};
  localparam int          CODES [5] = '{0, 2, 4, 7, 8};

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = !i_clk;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = !link_clk;
  end

  gauge_power_mode_sequencer u_gauge_power_mode_sequencer (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_link_clk(link_clk), .i_scl(!scl_low),
    .i_sda(!(sda_low || sda_oe)), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_int_n_o(int_o),
    .o_int_n_oe(int_oe), .i_vbat_ok(vbat_ok), .i_alarm_evt(evt), .o_gauge_run(run),
    .o_afe_power(afe), .o_cpu_clk_en(cpu), .o_power_state(pst)
  );
  gauge_host_model u_host (.i_sda(!(sda_low || sda_oe)), .o_scl_low(scl_low), .o_sda_low(sda_low));

  function automatic logic [7:0] status_exp(input logic go, input logic [1:0] ps);
    return {5'h00, ps, go};
  endfunction : status_exp

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("Checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic wait_state(input logic [1:0] s);
    int n;
    n = 0;
    while (pst !== s && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    check("power state", 16'(pst), 16'(s));
  endtask : wait_state

  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    u_host.wr(ra, d, ok);
    check("write ack", 16'(ok), 16'h0001);
    repeat (4) @(posedge i_clk);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] ra, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(ra, d, ok);
    check(what, 16'({ok, d}), 16'({1'b1, e}));
  endtask : rd_chk

  task automatic wake();
    u_host.wake(ok);
    check("wake nack", 16'(ok), 16'h0000);
    wait_state(2'b10);
  endtask : wake

  initial begin
    #3000000;
    miscompares++;
    print_verdict();
  end

  initial begin
    i_resetn = 1'b0;
    vbat_ok = 1'b1;
    evt = 16'h0000;
    miscompares = 0;
    checks_done = 0;
    seed = 69526;
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    wait_state(2'b01);
    u_host.wr(gauge_pkg::REG_MODE, 8'h00, ok);
    check("asleep write", 16'({ok, int_oe}), 16'h0000);
    @(posedge i_clk);
    vbat_ok <= 1'b0;
    u_host.wake(ok);
    repeat (4) @(posedge i_clk);
    check("no battery", 16'(pst), 16'h0001);
    vbat_ok <= 1'b1;
    wake();
    check("woken", 16'({sda_o, int_o, int_oe, afe, cpu}), 16'h0007);
    rd_chk("ready flag", gauge_pkg::REG_INT_HI, RDY[15:8]);
    wr(gauge_pkg::REG_MASK_HI, RDY[15:8]);
    check("masked", 16'(int_oe), 16'h0000);
    wr(gauge_pkg::REG_MASK_HI, 8'h00);
    wr(gauge_pkg::REG_CLR_HI, 8'h00);
    check("zero clear", 16'(int_oe), 16'h0001);
    wr(gauge_pkg::REG_CLR_HI, RDY[15:8]);
    check("cleared", 16'(int_oe), 16'h0000);
    foreach (LOCKED[i]) begin
      cfg_d[i] = 8'($random(seed));
      wr(LOCKED[i], cfg_d[i]);
    end
    wr(gauge_pkg::REG_MODE, 8'h01);
    check("gauging", 16'(run), 16'h0001);
    rd_chk("status", gauge_pkg::REG_STATUS, status_exp(1'b1, 2'b10));
    foreach (LOCKED[i]) begin
      wr(LOCKED[i], ~cfg_d[i]);
      rd_chk("locked", LOCKED[i], cfg_d[i]);
    end
    off = int'($unsigned($random(seed)) % 5);
    foreach (CODES[i]) begin
      ev = 16'h0001 << CODES[(i + off) % 5];
      @(posedge i_clk);
      evt <= ev;
      @(posedge i_clk);
      evt <= 16'h0000;
      repeat (3) @(posedge i_clk);
      check("event int", 16'(int_oe), 16'h0001);
      wr(ev[8] ? gauge_pkg::REG_CLR_HI : gauge_pkg::REG_CLR_LO, ev[8] ? ev[15:8] : ev[7:0]);
      check("event cleared", 16'(int_oe), 16'h0000);
    end
    wr(gauge_pkg::REG_MODE, 8'h00);
    wr(gauge_pkg::CFG_FIRST, 8'h5A);
    rd_chk("unlocked", gauge_pkg::CFG_FIRST, 8'h5A);
    wr(gauge_pkg::REG_MODE, {5'h00, gauge_pkg::PM_HIBERNATE, 1'b0});
    check("hibernate", 16'({pst, afe, cpu}), 16'h000C);
    wr(gauge_pkg::CFG_LAST, 8'hC3);
    rd_chk("retained", gauge_pkg::CFG_FIRST, 8'h5A);
    rd_chk("hibernate write", gauge_pkg::CFG_LAST, 8'hC3);
    fork
      wr(gauge_pkg::REG_MODE, {5'h00, gauge_pkg::PM_SHUTDOWN, 1'b0});
      wait (pst !== 2'b11) check("wipe", 16'(pst), 16'h0000);
    join
    wait_state(2'b01);
    wake();
    wr(gauge_pkg::REG_MASK_LO, 8'hFF);
    u_host.wr(gauge_pkg::REG_RESET, gauge_pkg::RESET_KEY, ok);
    wait_state(2'b01);
    wake();
    rd_chk("mask default", gauge_pkg::REG_MASK_LO, 8'h00);
    rd_chk("status default", gauge_pkg::REG_STATUS, status_exp(1'b0, 2'b10));
    rd_chk("ready again", gauge_pkg::REG_INT_HI, RDY[15:8]);
    print_verdict();
  end
endmodule : tb
